// *** mmrd_map.vh ***
// Address map, remap register and exception vector constants for the memory decoder
`ifndef MMRD_MAP_VH
`define MMRD_MAP_VH
`define MMRD_ALIAS_TOP 32'h00007800
`define MMRD_SRAM_BASE 32'h00040000
`define MMRD_SRAM_TOP 32'h00041000
`define MMRD_FLASH_BASE 32'h00080000
`define MMRD_FLASH_USER_TOP 32'h00087800
`define MMRD_FLASH_TOP 32'h00088000
`define MMRD_PERIPH_BASE 32'hFFFFF000
`define MMRD_REMAP_ADDR 32'hFFFF0220
`define MMRD_REMAP_RESET 8'h00
`define MMRD_REMAP_BIT 0
`define MMRD_SRAM_AW 10
`define MMRD_SIZE_BYTE 2'h0
`define MMRD_SIZE_HALF 2'h1
`define MMRD_SIZE_WORD 2'h2
`define MMRD_VEC_RESET 5'h00
`define MMRD_VEC_UNDEF 5'h04
`define MMRD_VEC_TRAP 5'h08
`define MMRD_VEC_PABORT 5'h0C
`define MMRD_VEC_DABORT 5'h10
`define MMRD_VEC_KEY 5'h14
`define MMRD_VEC_IRQ 5'h18
`define MMRD_VEC_FIQ 5'h1C
`define MMRD_BOOT_KEY 32'h27011970
`define MMRD_IRQ_MIN_CYC 5
`define MMRD_FIQ_MAX_CYC 50
`endif

// *** mmrd_sram.v ***
// Byte-lane writable 1024 x 32 SRAM
`timescale 1ns/1ps
`include "mmrd_map.vh"
module mmrd_sram (
  input wire i_clk_sys,
  input wire i_en,
  input wire i_we,
  input wire [3:0] i_be,
  input wire [`MMRD_SRAM_AW-1:0] i_addr,
  input wire [31:0] i_wdata,
  output reg [31:0] o_rdata
);
  reg [31:0] mem [0:(1<<`MMRD_SRAM_AW)-1];
  wire [31:0] wr_mask;
  genvar g;
  // Byte enables widened to a bit mask, lane 0 is the lowest byte address
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      assign wr_mask[8*g+7:8*g] = {8{i_be[g]}};
    end
  endgenerate
  // One writer for the whole array keeps a single driver; masked-out lanes keep their bytes
  always @(posedge i_clk_sys)
  begin
    if (i_en && i_we)
      mem[i_addr] <= (mem[i_addr] & ~wr_mask) | (i_wdata & wr_mask);
  end
  // Synchronous read, no reset needed for array contents
  always @(posedge i_clk_sys)
  begin
    if (i_en)
      o_rdata <= mem[i_addr];
  end
endmodule // mmrd_sram

// *** mmrd_decoder.v ***
// Memory map decoder with remappable low window, SRAM, flash port and register area
`timescale 1ns/1ps
`include "mmrd_map.vh"
module mmrd_decoder (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_req,
  input wire i_we,
  input wire i_kernel,
  input wire [1:0] i_size,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  output reg o_ack,
  output reg o_abort,
  output reg [31:0] o_rdata,
  output wire o_flash_req,
  output wire [14:0] o_flash_addr,
  input wire [31:0] i_flash_rdata,
  output wire o_periph_req,
  output wire o_periph_we,
  output wire [11:0] o_periph_addr,
  output wire [31:0] o_periph_wdata,
  output wire [3:0] o_periph_be,
  input wire [31:0] i_periph_rdata,
  output wire o_remap_sram,
  input wire i_irq_pin,
  input wire i_fiq_pin,
  input wire i_trap,
  input wire i_undef,
  input wire i_pabort,
  output reg o_exc_valid,
  output reg [4:0] o_exc_vector,
  output reg o_irq_sync,
  output reg o_fiq_sync
);
  // Decode targets of one access
  localparam T_NONE = 3'h0;
  localparam T_SRAM = 3'h1;
  localparam T_FLASH = 3'h2;
  localparam T_PERIPH = 3'h3;
  localparam T_REMAP = 3'h4;
  // Remap bit, access pipeline and synchroniser state
  reg [7:0] remap_q;
  reg [2:0] tgt_q;
  reg [31:0] dat_q;
  reg pend_q;
  reg dabort_q;
  reg [2:0] irq_s_q;
  reg [2:0] fiq_s_q;
  // Combinational decode results
  wire [31:0] sram_rdata;
  wire [2:0] tgt;
  wire [31:0] phys;
  wire [3:0] be;
  // Lane enables from size and low address bits, little endian
  function [3:0] lanes;
    input [1:0] sz;
    input [1:0] a;
    begin
      case (sz)
        `MMRD_SIZE_BYTE: lanes = 4'h1 << a;
        `MMRD_SIZE_HALF: lanes = a[1] ? 4'hC : 4'h3;
        default: lanes = 4'hF;
      endcase
    end
  endfunction
  // Map an address to its target, alias resolved from the current remap bit
  function [2:0] decode;
    input [31:0] a;
    input sram_sel;
    input kern;
    begin
      if (a < `MMRD_ALIAS_TOP)
        // Key word at 0x14 reads through the alias like any vector; checking it is kernel code
        decode = sram_sel ? ((a < (`MMRD_SRAM_TOP - `MMRD_SRAM_BASE)) ? T_SRAM : T_NONE) : T_FLASH;
      else if (a >= `MMRD_SRAM_BASE && a < `MMRD_SRAM_TOP)
        decode = T_SRAM;
      else if (a >= `MMRD_FLASH_BASE && a < `MMRD_FLASH_USER_TOP)
        decode = T_FLASH;
      else if (a >= `MMRD_FLASH_USER_TOP && a < `MMRD_FLASH_TOP)
        decode = kern ? T_FLASH : T_NONE;
      else if (a == `MMRD_REMAP_ADDR)
        decode = T_REMAP;
      else if (a >= `MMRD_PERIPH_BASE)
        decode = T_PERIPH;
      else
        decode = T_NONE;
    end
  endfunction
  // Decode uses the registered remap bit only; a write lands at its taking edge, one cycle before its ack
  assign tgt = decode(i_addr, remap_q[`MMRD_REMAP_BIT], i_kernel);
  assign be = lanes(i_size, i_addr[1:0]);
  assign phys = (i_addr < `MMRD_ALIAS_TOP && remap_q[`MMRD_REMAP_BIT]) ? (i_addr + `MMRD_SRAM_BASE) :
                (i_addr < `MMRD_ALIAS_TOP) ? (i_addr + `MMRD_FLASH_BASE) : i_addr;
  // Strobes to flash and register area; flash is never written from this bus
  assign o_flash_req = i_req && (tgt == T_FLASH) && !i_we;
  assign o_flash_addr = phys[14:0];
  assign o_periph_req = i_req && (tgt == T_PERIPH);
  assign o_periph_we = i_we;
  assign o_periph_addr = i_addr[11:0];
  assign o_periph_wdata = i_wdata;
  assign o_periph_be = be;
  // Remap bit shown to the core
  assign o_remap_sram = remap_q[`MMRD_REMAP_BIT];
  // SRAM word index from the physical address, alias already folded in
  mmrd_sram u_sram (
    .i_clk_sys(i_clk_sys),
    .i_en(i_req && (tgt == T_SRAM)),
    .i_we(i_we),
    .i_be(be),
    .i_addr(phys[`MMRD_SRAM_AW+1:2]),
    .i_wdata(i_wdata),
    .o_rdata(sram_rdata)
  );
  // Remap register; reset of any kind returns flash to address zero
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      remap_q <= `MMRD_REMAP_RESET;
    // Only lane 0 carries the bit; reserved bits always read back zero
    else if (i_req && i_we && tgt == T_REMAP && be[0])
      remap_q <= {7'h00, i_wdata[`MMRD_REMAP_BIT]};
  end
  // Access pipeline: two cycles from request to ack or abort
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend_q <= 1'b0;
      tgt_q <= T_NONE;
      dat_q <= 32'h00000000;
      dabort_q <= 1'b0;
    end
    else
    begin
      // Far side answers combinationally, so data is caught at the taking edge
      pend_q <= i_req;
      tgt_q <= tgt;
      dat_q <= (tgt == T_FLASH) ? i_flash_rdata : (tgt == T_PERIPH) ? i_periph_rdata : {24'h000000, remap_q};
      dabort_q <= i_req && ((tgt == T_NONE) || (tgt == T_FLASH && i_we));
    end
  end
  // Answer stage; flash is read only through this port
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ack <= 1'b0;
      o_abort <= 1'b0;
      o_rdata <= 32'h00000000;
    end
    else
    begin
      o_ack <= pend_q && !dabort_q;
      o_abort <= pend_q && dabort_q;
      o_rdata <= (tgt_q == T_SRAM) ? sram_rdata : dat_q;
    end
  end
  // Three-stage interrupt synchronisers, change accepted when stages two and three agree
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_s_q <= 3'h0;
      fiq_s_q <= 3'h0;
      o_irq_sync <= 1'b0;
      o_fiq_sync <= 1'b0;
    end
    else
    begin
      irq_s_q <= {irq_s_q[1:0], i_irq_pin};
      fiq_s_q <= {fiq_s_q[1:0], i_fiq_pin};
      // Agreement of two stages keeps a one-cycle glitch away from the core
      if (irq_s_q[1] == irq_s_q[2])
        o_irq_sync <= irq_s_q[2];
      if (fiq_s_q[1] == fiq_s_q[2])
        o_fiq_sync <= fiq_s_q[2];
    end
  end
  // Exception arbiter: highest pending source wins the vector
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_exc_valid <= 1'b1;
      o_exc_vector <= `MMRD_VEC_RESET;
    end
    else
    begin
      o_exc_valid <= o_abort || o_fiq_sync || o_irq_sync || i_pabort || i_trap || i_undef;
      if (o_abort)
        o_exc_vector <= `MMRD_VEC_DABORT;
      else if (o_fiq_sync)
        o_exc_vector <= `MMRD_VEC_FIQ;
      else if (o_irq_sync)
        o_exc_vector <= `MMRD_VEC_IRQ;
      else if (i_pabort)
        o_exc_vector <= `MMRD_VEC_PABORT;
      // Trap and undefined never come together, so their order here is free
      else if (i_trap)
        o_exc_vector <= `MMRD_VEC_TRAP;
      else if (i_undef)
        o_exc_vector <= `MMRD_VEC_UNDEF;
      else
        o_exc_vector <= `MMRD_VEC_RESET;
    end
  end
endmodule // mmrd_decoder

// *** mmrd_decoder_sva.sv ***
// Port checks for the memory map decoder
`timescale 1ns/1ps
module mmrd_decoder_sva (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_req,
  input wire i_we,
  input wire i_kernel,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  input wire o_ack,
  input wire o_abort,
  input wire o_flash_req,
  input wire [14:0] o_flash_addr,
  input wire o_remap_sram,
  input wire o_exc_valid,
  input wire [4:0] o_exc_vector
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Answer lands two edges after the taking edge
  sequence s_answer; ##2 (o_ack ^ o_abort); endsequence
  sequence s_abort; ##2 o_abort; endsequence
  a_answer_timed: assert property (i_req |-> s_answer) else $error("missing answer");
  a_no_stray: assert property (!$past(i_req, 2) |-> !(o_ack || o_abort)) else $error("stray answer");
  a_undef_abort: assert property (i_req && i_addr[31:20] == 12'h001 |-> s_abort) else $error("no abort");
  a_flash_wr: assert property (i_req && i_we && i_addr[31:15] == 17'h00010 |-> s_abort) else $error("flash wr");
  a_kernel_gate: assert property (i_req && !i_kernel && i_addr[31:11] == 21'h0010F |-> s_abort)
    else $error("kernel reached");
  a_alias_flash: assert property (i_req && !o_remap_sram && i_addr < 32'h7800 && !i_we
    |-> o_flash_req && o_flash_addr == i_addr[14:0]) else $error("alias not flash");
  a_remap_write: assert property (i_req && i_we && i_addr == 32'hFFFF0220 |=> o_remap_sram == $past(i_wdata[0]))
    else $error("remap write lost");
  a_remap_hold: assert property (!$past(i_req && i_we) |-> $stable(o_remap_sram)) else $error("remap moved");
  a_abort_vector: assert property (o_abort |=> o_exc_valid && o_exc_vector == 5'h10) else $error("abort vector");
endmodule // mmrd_decoder_sva
bind mmrd_decoder mmrd_decoder_sva u_sva (.*);

// *** mmrd_far_model.sv ***
// Flash and register-area read model behind the decoder
`timescale 1ns/1ps
module mmrd_far_model (
  input wire i_clk_sys,
  input wire i_flash_req,
  input wire [14:0] i_flash_addr,
  input wire i_periph_req,
  input wire [11:0] i_periph_addr,
  output logic [31:0] o_flash_rdata,
  output logic [31:0] o_periph_rdata
);
  logic [31:0] flash_q, per_q;
  // Words tied to offsets; idle buses toggle so stale data never matches
  assign o_flash_rdata = i_flash_req ? {17'h1B4A5, i_flash_addr[14:2], 2'h0} : ~flash_q;
  assign o_periph_rdata = i_periph_req ? {20'hC3C3C, i_periph_addr} : ~per_q;
  // Last value seen on each bus
  always @(posedge i_clk_sys) flash_q <= o_flash_rdata;
  always @(posedge i_clk_sys) per_q <= o_periph_rdata;
endmodule // mmrd_far_model

// *** mmrd_decoder_tb.sv ***
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module mmrd_decoder_tb;
  logic i_clk_sys = 0, i_rst = 1, i_req = 0, i_we = 0, i_kernel = 0;
  logic i_irq_pin = 0, i_fiq_pin = 0, i_trap = 0, i_undef = 0, i_pabort = 0;
  logic [1:0] i_size = 2'h2;
  logic [31:0] i_addr = 32'h0, i_wdata = 32'h0;
  logic o_ack, o_abort, o_flash_req, o_periph_req, o_periph_we, o_remap_sram, o_exc_valid, o_irq_sync, o_fiq_sync;
  logic [31:0] o_rdata, i_flash_rdata, i_periph_rdata, o_periph_wdata;
  logic [14:0] o_flash_addr;
  logic [11:0] o_periph_addr;
  logic [3:0] o_periph_be;
  logic [4:0] o_exc_vector;
  int failures = 0, check_count = 0;
  mmrd_decoder DUT (.*);
  mmrd_far_model u_far (
    .i_clk_sys(i_clk_sys),
    .i_flash_req(o_flash_req),
    .i_flash_addr(o_flash_addr),
    .i_periph_req(o_periph_req),
    .i_periph_addr(o_periph_addr),
    .o_flash_rdata(i_flash_rdata),
    .o_periph_rdata(i_periph_rdata)
  );
  // 250 MHz clock
  always #2 i_clk_sys = ~i_clk_sys;
  function logic [31:0] fw(input logic [31:0] a);
    return {17'h1B4A5, a[14:2], 2'h0};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access from a falling edge; returns in the answer cycle
  task acc(input logic we, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] wd);
    {i_req, i_we, i_size, i_addr, i_wdata} = {1'b1, we, sz, a, wd};
    @(negedge i_clk_sys);
    i_req = 0;
    @(negedge i_clk_sys);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    acc(0, 2'h2, a, 32'h0);
    chk({o_ack, o_abort, o_rdata[29:0]}, {2'h2, exp[29:0]});
    chk(o_rdata, exp);
  endtask
  task ab(input logic we, input logic [31:0] a);
    acc(we, 2'h2, a, 32'h0);
    chk(32'({o_ack, o_abort}), 32'h1);
  endtask
  task t_boot;
    chk(32'(o_remap_sram), 32'h0);
    chk(32'({o_exc_valid, o_exc_vector}), 32'h20);
    rd(32'h0, fw(32'h0));
    rd(32'h14, fw(32'h14));
    rd(32'h1C, fw(32'h1C));
    rd(32'h80004, fw(32'h4));
    i_kernel = 1;
    rd(32'h87800, fw(32'h7800));
    i_kernel = 0;
    rd(32'hFFFFF004, {20'hC3C3C, 12'h004});
    // Halfword write to the register area, strobes looked at mid-cycle
    {i_req, i_we, i_size, i_addr, i_wdata} = {1'b1, 1'b1, 2'h1, 32'hFFFFF006, 32'h56780000};
    #1;
    chk(32'({o_periph_req, o_periph_we, o_periph_be, o_periph_addr}), {14'h0, 1'b1, 1'b1, 4'hC, 12'h006});
    chk(o_periph_wdata, 32'h56780000);
    @(negedge i_clk_sys);
    i_req = 0;
    @(negedge i_clk_sys);
    chk(32'({o_ack, o_abort}), 32'h2);
    $display("boot map done");
  endtask
  task t_sram;
    acc(1, 2'h2, 32'h40FFC, 32'h11223344);
    acc(1, 2'h0, 32'h40FFD, 32'h0000AA00);
    acc(1, 2'h1, 32'h40FFE, 32'hBEEF0000);
    rd(32'h40FFC, 32'hBEEFAA44);
    $display("sram lanes done");
  endtask
  task t_remap;
    acc(1, 2'h2, 32'hFFFF0220, 32'h1);
    rd(32'hFFFF0220, 32'h1);
    rd(32'h0FFC, 32'hBEEFAA44);
    ab(0, 32'h1000);
    // Clear then read zero in the very next cycle
    {i_we, i_addr, i_wdata, i_req} = {1'b1, 32'hFFFF0220, 32'h0, 1'b1};
    @(negedge i_clk_sys);
    {i_we, i_addr} = {1'b0, 32'h0};
    @(negedge i_clk_sys);
    i_req = 0;
    @(negedge i_clk_sys);
    chk(o_rdata, fw(32'h0));
    acc(1, 2'h2, 32'hFFFF0220, 32'h1);
    i_rst = 1;
    @(negedge i_clk_sys);
    i_rst = 0;
    chk(32'(o_remap_sram), 32'h0);
    chk(32'({o_exc_valid, o_exc_vector}), 32'h20);
    $display("remap done");
  endtask
  task t_abort;
    logic [31:0] bad [5] = '{32'h80000, 32'h100000, 32'h8000, 32'h87800, 32'h41000};
    foreach (bad[k]) ab(k == 0, bad[k]);
    $display("abort done");
  endtask
  task t_exc;
    // fiq, irq, prefetch, trap, undef; trap and undef never both
    logic [9:0] tv [6] = '{{5'h06, 5'h0C}, {5'h14, 5'h1C}, {5'h18, 5'h1C}, {5'h08, 5'h18}, {5'h01, 5'h04},
      {5'h02, 5'h08}};
    // Pin seen four edges on, vector one edge later
    i_irq_pin = 1;
    repeat (3) @(negedge i_clk_sys);
    chk(32'(o_irq_sync), 32'h0);
    @(negedge i_clk_sys);
    chk(32'(o_irq_sync), 32'h1);
    @(negedge i_clk_sys);
    chk(32'({o_exc_valid, o_exc_vector}), 32'h38);
    foreach (tv[k])
    begin
      {i_fiq_pin, i_irq_pin, i_pabort, i_trap, i_undef} = tv[k][9:5];
      repeat (6) @(negedge i_clk_sys);
      chk(32'(o_exc_vector), 32'(tv[k][4:0]));
    end
    {i_fiq_pin, i_undef, i_trap} = 3'h4;
    repeat (6) @(negedge i_clk_sys);
    ab(0, 32'h100000);
    @(negedge i_clk_sys);
    chk(32'(o_exc_vector), 32'h10);
    chk(32'(o_fiq_sync), 32'h1);
    i_fiq_pin = 0;
    repeat (6) @(negedge i_clk_sys);
    chk(32'({o_exc_valid, o_exc_vector}), 32'h0);
    $display("exceptions done");
  endtask
  task complete_run;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well past the roughly 110 cycles needed
  initial
  begin
    #20000;
    failures++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(negedge i_clk_sys);
    i_rst = 0;
    t_boot();
    t_sram();
    t_remap();
    t_abort();
    t_exc();
    complete_run();
  end
endmodule // mmrd_decoder_tb
